// ===== logic/rrci_cfg.svh
// Constants for the round-robin core issue scheduler
`ifndef RRCI_CFG_SVH
`define RRCI_CFG_SVH
`define RRCI_NUM_CTX    5
`define RRCI_CTX_W      3
`define RRCI_PIPE_DEPTH 4
`define RRCI_HIST_LEN   3
`define RRCI_SLOT_W     2
`define RRCI_SRC_CHAN   2'h0
`define RRCI_SRC_TIMER  2'h1
`define RRCI_SRC_PORT   2'h2
`define RRCI_SRC_NONE   2'h3
`define RRCI_TIME_W     32
`define RRCI_CTX_ZERO   3'h0
`define RRCI_CTX_ONE    3'h1
`endif

// ===== logic/rrci_pkg.sv
// Types for the round-robin core issue scheduler
`include "rrci_cfg.svh"
package rrci_pkg;
	typedef logic [`RRCI_CTX_W-1:0]  rrci_ctx_t;
	typedef logic [`RRCI_NUM_CTX-1:0] rrci_mask_t;
	typedef logic [`RRCI_SLOT_W-1:0] rrci_src_t;
	typedef logic [`RRCI_TIME_W-1:0] rrci_time_t;
	// Pause request from a running context
	typedef struct packed {
		logic      valid;
		rrci_ctx_t ctx;
		rrci_src_t src;
		rrci_time_t deadline;
	} rrci_wait_s;
	// Issue slot as seen by the pipeline
	typedef struct packed {
		logic      valid;
		rrci_ctx_t ctx;
	} rrci_issue_s;
	typedef enum logic [1:0] {
		RRCI_IDLE,
		RRCI_RUN,
		RRCI_WAIT
	} rrci_state_e;
endpackage

// ===== logic/rrci_sync.sv
// Two-stage synchroniser for event pins
`timescale 1ns/10ps
module rrci_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] out_d;

	// Next values; first stage feeds only the second
	always_comb begin
		meta_d = din;
		out_d  = meta_q;
	end

	// Registers cleared on reset
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= meta_d;
			dout   <= out_d;
		end
	end
endmodule

// ===== logic/rrci_ctx.sv
// Per-context wait and wake state
`timescale 1ns/10ps
`include "rrci_cfg.svh"
module rrci_ctx
	import rrci_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic        done,
	input  wire logic        wait_req,
	input  wire rrci_src_t   wait_src,
	input  wire rrci_time_t  deadline,
	input  wire rrci_time_t  now,
	input  wire logic        chan_evt,
	input  wire logic        port_evt,
	output logic             active,
	output logic             waiting,
	output logic             woke
);
	rrci_state_e state_q, state_d;
	rrci_src_t   src_q, src_d;
	rrci_time_t  dl_q, dl_d;
	logic        pend_q, pend_d;
	logic        hit;
	logic        woke_d;

	// Wake condition for the awaited source
	always_comb begin
		hit = 1'b0;
		case (src_q)
			`RRCI_SRC_CHAN:  hit = chan_evt;
			`RRCI_SRC_TIMER: hit = ($signed(now - dl_q) >= 0);
			`RRCI_SRC_PORT:  hit = port_evt;
			default:         hit = 1'b0;
		endcase
	end

	// Context state machine
	always_comb begin
		state_d = state_q;
		src_d   = src_q;
		dl_d    = dl_q;
		woke_d  = 1'b0;
		// Remember channel or port events in any state; one flag, so repeats merge
		pend_d  = pend_q | chan_evt | port_evt;
		case (state_q)
			RRCI_IDLE: begin
				if (start) begin
					state_d = RRCI_RUN;
				end
			end
			RRCI_RUN: begin
				if (done) begin
					state_d = RRCI_IDLE;
				end else if (wait_req) begin
					state_d = RRCI_WAIT;
					src_d   = wait_src;
					dl_d    = deadline;
				end
			end
			RRCI_WAIT: begin
				if (hit || (pend_q && src_q != `RRCI_SRC_TIMER)) begin
					state_d = RRCI_RUN;
					woke_d  = 1'b1;
					// Consume one event; any other arriving now stays pending
					if (src_q != `RRCI_SRC_TIMER) begin
						if (pend_q) begin
							pend_d = chan_evt | port_evt;
						end else if (src_q == `RRCI_SRC_CHAN) begin
							pend_d = port_evt;
						end else begin
							pend_d = chan_evt;
						end
					end
				end
			end
			default: state_d = RRCI_IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= RRCI_IDLE;
			src_q   <= `RRCI_SRC_NONE;
			dl_q    <= '0;
			pend_q  <= 1'b0;
			woke    <= 1'b0;
		end else begin
			state_q <= state_d;
			src_q   <= src_d;
			dl_q    <= dl_d;
			pend_q  <= pend_d;
			woke    <= woke_d;
		end
	end

	assign active  = (state_q == RRCI_RUN);
	assign waiting = (state_q == RRCI_WAIT);
endmodule

// ===== logic/rrci_top.sv
// Round-robin issue scheduler for one tile
//
// Behaviour
// - Five thread contexts share one four-stage pipeline.
// - Next issue comes from active contexts in strict round-robin order.
// - With four or fewer active, each context gets one slot in four.
// - With n above four active, each gets at least one of n slots.
// - With more than four active, slots of stalled contexts go to other ready contexts; with four or fewer, only to one not issued in the last three cycles.
// - Contexts start on hardware events and run to completion.
// - A context may suspend itself and leaves the rotation.
// - Channel and port events share one pending flag per context; repeats merge and either kind ends a channel or port wait.
// - Pin events go straight to the scheduler without polling.
// - Wait until a time elapses or channel data arrives.
`timescale 1ns/10ps
`include "rrci_cfg.svh"
module rrci_top
	import rrci_pkg::*;
#(
	parameter int NCTX = `RRCI_NUM_CTX
) (
	input  wire logic                CLK,
	input  wire logic                RST,
	input  wire rrci_mask_t          START,
	input  wire rrci_mask_t          DONE,
	input  wire rrci_wait_s          WAIT_REQ,
	input  wire rrci_mask_t          CHAN_EVT,
	input  wire rrci_mask_t          PIN_EVT,
	input  wire rrci_mask_t          STALL,
	output rrci_issue_s              ISSUE,
	output rrci_mask_t               ACTIVE,
	output rrci_mask_t               WAITING,
	output rrci_mask_t               WOKE,
	output rrci_time_t               NOW
);
	import rrci_pkg::*;

	rrci_mask_t  pin_s;
	rrci_mask_t  act;
	rrci_mask_t  wt;
	rrci_mask_t  wk;
	rrci_mask_t  ready;
	rrci_time_t  now_q, now_d;
	rrci_ctx_t   last_q, last_d;
	rrci_mask_t  hist_q [`RRCI_HIST_LEN];
	rrci_mask_t  hist_d [`RRCI_HIST_LEN];
	rrci_mask_t  issued;
	rrci_mask_t  recent;
	rrci_mask_t  fresh;
	logic        fresh_ok;
	rrci_ctx_t   fresh_pick;
	rrci_issue_s issue_d;
	logic [`RRCI_CTX_W:0] act_cnt;
	logic        pick_ok;
	rrci_ctx_t   pick;
	rrci_ctx_t   cand;

	rrci_sync #(
		.W(NCTX)
	) u_pin_sync (
		.clk  (CLK),
		.rst  (RST),
		.din  (PIN_EVT),
		.dout (pin_s)
	);

	genvar gi;
	generate
		for (gi = 0; gi < NCTX; gi++) begin : g_ctx
			rrci_ctx u_ctx (
				.clk      (CLK),
				.rst      (RST),
				.start    (START[gi]),
				.done     (DONE[gi]),
				.wait_req (WAIT_REQ.valid && WAIT_REQ.ctx == gi),
				.wait_src (WAIT_REQ.src),
				.deadline (WAIT_REQ.deadline),
				.now      (now_q),
				.chan_evt (CHAN_EVT[gi]),
				.port_evt (pin_s[gi]),
				.active   (act[gi]),
				.waiting  (wt[gi]),
				.woke     (wk[gi])
			);
		end
	endgenerate

	assign ready = act & ~STALL;

	// Count of running contexts
	always_comb begin
		act_cnt = '0;
		for (int i = 0; i < NCTX; i++) begin
			act_cnt = act_cnt + {{`RRCI_CTX_W{1'b0}}, act[i]};
		end
	end

	// Contexts that issued in any of the previous three cycles
	always_comb begin
		recent = '0;
		for (int h = 0; h < `RRCI_HIST_LEN; h++) begin
			recent = recent | hist_q[h];
		end
	end

	// Spacing keeps one instruction per context in the pipeline
	assign fresh = ready & ~recent;

	always_comb begin
		pick_ok    = 1'b0;
		pick       = last_q;
		fresh_ok   = 1'b0;
		fresh_pick = last_q;
		cand       = last_q;
		for (int k = 1; k <= NCTX; k++) begin
			cand = (cand == rrci_ctx_t'(NCTX - 1)) ? `RRCI_CTX_ZERO : cand + `RRCI_CTX_ONE;
			if (!pick_ok && ready[cand]) begin
				pick_ok = 1'b1;
				pick    = cand;
			end
			if (!fresh_ok && fresh[cand]) begin
				fresh_ok   = 1'b1;
				fresh_pick = cand;
			end
		end
	end

	// Issue decision and time base
	always_comb begin
		now_d   = now_q + 1'b1;
		last_d  = last_q;
		issue_d = '0;
		if (act_cnt <= `RRCI_PIPE_DEPTH) begin
			// Fewer than four leave bubbles; a share never depends on the others
			if (fresh_ok) begin
				issue_d.valid = 1'b1;
				issue_d.ctx   = fresh_pick;
				last_d        = fresh_pick;
			end
		end else if (pick_ok) begin
			issue_d.valid = 1'b1;
			issue_d.ctx   = pick;
			last_d        = pick;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			now_q  <= '0;
			last_q <= rrci_ctx_t'(NCTX - 1);
			ISSUE  <= '0;
		end else begin
			now_q  <= now_d;
			last_q <= last_d;
			ISSUE  <= issue_d;
		end
	end

	// Issue history shifts by one each cycle
	always_comb begin
		issued = '0;
		if (issue_d.valid) begin
			issued[issue_d.ctx] = 1'b1;
		end
		hist_d[0] = issued;
		for (int h = 1; h < `RRCI_HIST_LEN; h++) begin
			hist_d[h] = hist_q[h-1];
		end
	end

	// History cleared on reset
	always_ff @(posedge CLK) begin
		for (int h = 0; h < `RRCI_HIST_LEN; h++) begin
			if (RST) begin
				hist_q[h] <= '0;
			end else begin
				hist_q[h] <= hist_d[h];
			end
		end
	end

	assign ACTIVE  = act;
	assign WAITING = wt;
	assign WOKE    = wk;
	assign NOW     = now_q;
endmodule

// ===== verification/rrci_evt_model.sv
// Event source model: channel ends and pins
`timescale 1ns/10ps
module rrci_evt_model
	import rrci_pkg::*;
(
	input  wire logic       clk,
	input  wire rrci_mask_t chan_go,
	input  wire rrci_mask_t pin_go,
	output rrci_mask_t      chan_evt,
	output rrci_mask_t      pin_evt
);
	rrci_mask_t cp = 0, pp = 0;
	initial chan_evt = 0;
	initial pin_evt = 0;
	// Sample requests, then drive off the sampling edge
	always @(posedge clk) begin
		cp <= chan_go;
		pp <= pin_go;
	end
	// each output follows its request, channel and pin alike
	always @(negedge clk) begin
		chan_evt <= cp;
		pin_evt <= pp;
	end
endmodule

// ===== verification/rrci_top_monitor.sv
// Port checker for the issue scheduler
`timescale 1ns/10ps
module rrci_monitor
	import rrci_pkg::*;
#(
	parameter int NCTX = 5
) (
	input wire logic        CLK,
	input wire logic        RST,
	input wire rrci_mask_t  START,
	input wire rrci_mask_t  DONE,
	input wire rrci_wait_s  WAIT_REQ,
	input wire rrci_mask_t  STALL,
	input wire rrci_issue_s ISSUE,
	input wire rrci_mask_t  ACTIVE,
	input wire rrci_mask_t  WOKE,
	input wire rrci_time_t  NOW
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// All five ready, no pause or finish pending
	sequence full_ring;
		ISSUE.valid && $past(ISSUE.valid) && $past(ACTIVE & ~STALL) == 5'h1F
			&& !$past(WAIT_REQ.valid) && $past(DONE) == 5'h00;
	endsequence
	// Slot ownership, waking and time base
	chk_rr_turn: assert property (full_ring |->
		ISSUE.ctx == rrci_ctx_t'(($past(ISSUE.ctx) + 1) % NCTX)) else $error("rr order");
	chk_issue_active: assert property (ISSUE.valid |->
		($past(ACTIVE) & (5'h01 << ISSUE.ctx)) != 5'h00) else $error("idle issued");
	chk_stall_skip: assert property (ISSUE.valid |->
		($past(STALL) & (5'h01 << ISSUE.ctx)) == 5'h00) else $error("stalled issued");
	chk_woke_act: assert property ((WOKE & ~ACTIVE) == 5'h00)
		else $error("woke not active");
	chk_now_tick: assert property (!$past(RST) |-> NOW == $past(NOW) + 32'h1)
		else $error("time stuck");
	chk_reset_quiet: assert property ($past(RST) |-> ACTIVE == 5'h00
		&& !ISSUE.valid && WOKE == 5'h00) else $error("busy after reset");
	chk_no_spont: assert property (!$past(RST) |->
		(ACTIVE & ~$past(ACTIVE) & ~$past(START) & ~WOKE) == 5'h00) else $error("self start");
	chk_done_idle: assert property ((ACTIVE & $past(DONE & ACTIVE)) == 5'h00)
		else $error("done ignored");
	chk_quarter_gap: assert property (ISSUE.valid && $countones($past(ACTIVE)) <= 4 |->
		!($past(ISSUE.valid) && $past(ISSUE.ctx) == ISSUE.ctx)
		&& !($past(ISSUE.valid, 2) && $past(ISSUE.ctx, 2) == ISSUE.ctx)
		&& !($past(ISSUE.valid, 3) && $past(ISSUE.ctx, 3) == ISSUE.ctx))
		else $error("quarter gap");
endmodule
bind rrci_top rrci_monitor #(.NCTX(NCTX)) mon (.CLK(CLK), .RST(RST), .START(START),
	.DONE(DONE), .WAIT_REQ(WAIT_REQ), .STALL(STALL), .ISSUE(ISSUE), .ACTIVE(ACTIVE),
	.WOKE(WOKE), .NOW(NOW));

// ===== verification/round_robin_core_issue_tb.sv
// Self-checking bench for the issue scheduler
`timescale 1ns/10ps
`include "rrci_cfg.svh"
module round_robin_core_issue_tb;
	import rrci_pkg::*;
	logic CLK = 0, RST = 1;
	rrci_mask_t START = 0, DONE = 0, STALL = 0, cgo = 0, pgo = 0;
	rrci_mask_t CHAN_EVT, PIN_EVT, ACTIVE, WAITING, WOKE;
	rrci_wait_s WAIT_REQ = 0;
	rrci_issue_s ISSUE;
	rrci_time_t NOW;
	int failures = 0, compares = 0, cycles = 0, i;
	int cnt [5];
	always #20 CLK = ~CLK;
	rrci_top dut (.CLK(CLK), .RST(RST), .START(START), .DONE(DONE), .WAIT_REQ(WAIT_REQ),
		.CHAN_EVT(CHAN_EVT), .PIN_EVT(PIN_EVT), .STALL(STALL), .ISSUE(ISSUE),
		.ACTIVE(ACTIVE), .WAITING(WAITING), .WOKE(WOKE), .NOW(NOW));
	rrci_evt_model far (.clk(CLK), .chan_go(cgo), .pin_go(pgo), .chan_evt(CHAN_EVT),
		.pin_evt(PIN_EVT));
	task results;
		if (failures == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge CLK);
	endtask
	task req(input int c, input rrci_src_t s, input rrci_time_t d);
		WAIT_REQ = {1'b1, c[2:0], s, d};
		cyc(1);
		WAIT_REQ = 0;
	endtask
	// Count issue slots per context
	task tally(input int n);
		cnt = '{default: 0};
		repeat (n) begin
			cyc(1);
			if (ISSUE.valid === 1'b1) cnt[ISSUE.ctx]++;
		end
	endtask
	task t_rotate;
		START = 5'h1F;
		cyc(1);
		START = 0;
		chk(ACTIVE, 5'h1F);
		tally(10);
		for (i = 0; i < 5; i++) chk(cnt[i], 32'h2);
	endtask
	task t_stall;
		STALL = 5'h07;
		cyc(1);
		tally(6);
		chk(cnt[0] + cnt[1] + cnt[2], 32'h0);
		chk(cnt[3], 32'h3);
		STALL = 0;
	endtask
	task t_chan;
		req(1, `RRCI_SRC_CHAN, 0);
		chk(WAITING, 5'h02);
		tally(5);
		chk(cnt[1], 32'h0);
		cgo = 5'h02;
		cyc(1);
		cgo = 0;
		cyc(1);
		chk(WOKE, 5'h02);
		chk(ACTIVE, 5'h1F);
		tally(5);
		chk(cnt[1], 32'h1);
	endtask
	// Timer wait must not end early
	task t_timer;
		rrci_time_t dl;
		dl = NOW + 32'h14;
		req(2, `RRCI_SRC_TIMER, dl);
		cyc(10);
		chk(WAITING[2], 1'h1);
		for (i = 0; i < 30 && WOKE[2] !== 1'b1; i++) cyc(1);
		chk(WOKE[2], 1'h1);
		chk(NOW, dl + 32'h1);
	endtask
	task t_pin;
		req(3, `RRCI_SRC_PORT, 0);
		pgo = 5'h08;
		for (i = 0; i < 10 && WOKE[3] !== 1'b1; i++) cyc(1);
		pgo = 0;
		chk(WOKE[3], 1'h1);
	endtask
	// Early event kept, finish all, idle pause, two-context share
	task t_done;
		cgo = 5'h10;
		cyc(1);
		cgo = 0;
		cyc(2);
		req(4, `RRCI_SRC_CHAN, 0);
		cyc(1);
		chk(WOKE[4], 1'h1);
		DONE = 5'h1F;
		cyc(1);
		DONE = 0;
		chk(ACTIVE, 5'h00);
		req(0, `RRCI_SRC_CHAN, 0);
		chk(WAITING, 5'h00);
		START = 5'h05;
		cyc(1);
		START = 0;
		cyc(4);
		tally(8);
		chk(cnt[0], 32'h2);
		chk(cnt[2], 32'h2);
	endtask
	initial begin
		cyc(10);
		RST = 0;
		t_rotate;
		t_stall;
		t_chan;
		t_timer;
		t_pin;
		t_done;
		results;
	end
	// Hang guard
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 1000) begin
			failures++;
			results;
		end
	end
endmodule
